// ### rtl/usb_node_config_regs.sv
// usb node configuration register bank with link control and status
`timescale 1ns/100ps
module usb_node_config_regs
  import usb_node_cfg_pkg::*;
#(
  parameter logic [7:0] CHIP_CODE = 8'h3c,        // arbitrary value
  parameter logic [7:0] REVISION  = 8'h11,        // arbitrary value
  parameter logic [7:0] VERSION   = 8'h07         // arbitrary value
) (
  input  wire logic       clk_in,                 // 20 mhz system clock
  input  wire logic       rst_in,                 // async reset, active high
  input  wire cfg_req_t   cfg_req_in,             // config read/write request
  output cfg_rsp_t        cfg_rsp_out,            // config answer, one cycle later
  input  wire link_stat_t link_stat_in,           // status from link logic
  output link_ctl_t       link_ctl_out,           // control to link logic
  output logic            header_size_select_out, // 1 selects one-byte headers
  output logic            update_lock_out,        // configuration frozen
  output logic [15:0]     node_number_out,        // node_number_field
  output logic [6:0]      clock_rate_mhz_out      // system clock in mhz
);

  // request and answer protocol:
  // a request is taken on the edge where valid is high
  // exactly one of ack or nack answers it on the next edge
  // ack, nack and read data stand for that one cycle only
  // requests may follow each other on every clock

  // whole state of the bank
  typedef struct packed {
    logic             lock;                       // update lock
    logic             hdr;                        // header_size_select
    logic [NODE_NUM_W-1:0] node_num;              // node_number_field
    logic [CLK_MHZ_W-1:0]  clk_mhz;               // clock_rate_mhz
    logic             rx_err;                     // sticky receive error
    logic [GAP_W-1:0] intra;                      // intra-token gap field
    logic [GAP_W-1:0] inter;                      // inter-token gap field
    logic             greet;                      // greeting strobe
    logic             rxrst;                      // receiver reset strobe
    logic             ack;                        // answer: accepted
    logic             nack;                       // answer: refused
    logic [31:0]      rdata;                      // answer: read data
  } state_t;

  state_t s_q;                                    // registered state
  state_t s_d;                                    // next state

  // the range check guards the stored clock value, so a refused
  // write can never leave an unusable frequency behind
  // true when a clock value sits in the legal range
  function automatic logic clk_in_range(input logic [CLK_MHZ_W-1:0] v);
    clk_in_range = (v >= CLK_MHZ_MIN) && (v <= CLK_MHZ_MAX);
  endfunction : clk_in_range

  // unmapped offsets are nacked rather than silently read as zero
  // true for the five offsets the bank decodes
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ADDR_IDENT) || (a == ADDR_NODE_SETUP) || (a == ADDR_NODE_NUM) ||
                  (a == ADDR_CLK_MHZ) || (a == ADDR_LINK_CS);
  endfunction : addr_mapped

  // credit flags are not stored here: they are read live from
  // the link logic on the edge that takes the read request
  // write-only strobe bits 24 and 23 always read back zero
  // read mux, reserved bits stay zero
  function automatic logic [31:0] read_word(input state_t s, input logic [7:0] a,
                                            input link_stat_t ls);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      ADDR_IDENT: begin
        w[IDENT_CHIP_LSB +: 8] = CHIP_CODE;
        w[IDENT_REV_LSB  +: 8] = REVISION;
        w[IDENT_VER_LSB  +: 8] = VERSION;
      end
      ADDR_NODE_SETUP: begin
        w[SETUP_LOCK_BIT] = s.lock;
        w[SETUP_HDR_BIT]  = s.hdr;
      end
      ADDR_NODE_NUM: begin
        w[NODE_NUM_W-1:0] = s.node_num;
      end
      ADDR_CLK_MHZ: begin
        w[CLK_MHZ_W-1:0] = s.clk_mhz;
      end
      ADDR_LINK_CS: begin
        w[LINK_RX_ERR_BIT]  = s.rx_err;
        w[LINK_RX_CRED_BIT] = ls.rx_credit;
        w[LINK_TX_CRED_BIT] = ls.tx_credit;
        w[LINK_INTRA_LSB +: GAP_W] = s.intra;
        w[LINK_INTER_LSB +: GAP_W] = s.inter;
      end
      default: begin
        w = 32'h0000_0000;                        // not reached: unmapped offsets are nacked before the mux
      end
    endcase
    read_word = w;
  endfunction : read_word

  // hazard notes for the next-state logic:
  // refused writes must leave every field untouched, so the
  // field updates sit behind take_wr and nothing else
  // the lock can only be set here; only reset clears it
  // the strobes default low so that a write pulses them once
  // next-state logic: request decode, field updates, strobes and answer
  always_comb begin
    logic take_wr;                                // write that may change state
    take_wr = 1'b0;
    s_d       = s_q;
    s_d.greet = 1'b0;                             // strobes last one cycle
    s_d.rxrst = 1'b0;
    s_d.ack   = 1'b0;
    s_d.nack  = 1'b0;
    s_d.rdata = 32'h0000_0000;

    // answer every request one cycle later
    if (cfg_req_in.valid) begin
      if (!addr_mapped(cfg_req_in.addr)) begin
        s_d.nack = 1'b1;                          // unmapped offset refused
      end else if (!cfg_req_in.write) begin
        s_d.ack   = 1'b1;
        s_d.rdata = read_word(s_q, cfg_req_in.addr, link_stat_in);
      end else if (s_q.lock && (cfg_req_in.addr != ADDR_IDENT)) begin
        s_d.nack = 1'b1;
      end else if ((cfg_req_in.addr == ADDR_CLK_MHZ) &&
                   !clk_in_range(cfg_req_in.wdata[CLK_MHZ_W-1:0])) begin
        s_d.nack = 1'b1;
      end else begin
        s_d.ack = 1'b1;
        take_wr = 1'b1;
      end
    end

    // accepted writes update their register
    if (take_wr) begin
      case (cfg_req_in.addr)
        ADDR_NODE_SETUP: begin
          s_d.lock = cfg_req_in.wdata[SETUP_LOCK_BIT];
          s_d.hdr  = cfg_req_in.wdata[SETUP_HDR_BIT];
        end
        ADDR_NODE_NUM: begin
          s_d.node_num = cfg_req_in.wdata[NODE_NUM_W-1:0];
        end
        ADDR_CLK_MHZ: begin
          s_d.clk_mhz = cfg_req_in.wdata[CLK_MHZ_W-1:0];
        end
        ADDR_LINK_CS: begin
          s_d.greet = cfg_req_in.wdata[LINK_GREET_BIT];
          s_d.rxrst = cfg_req_in.wdata[LINK_RXRST_BIT];
          s_d.intra = cfg_req_in.wdata[LINK_INTRA_LSB +: GAP_W];
          s_d.inter = cfg_req_in.wdata[LINK_INTER_LSB +: GAP_W];
          if (cfg_req_in.wdata[LINK_RXRST_BIT]) begin
            s_d.rx_err = 1'b0;                    // receiver reset clears error
          end
        end
        default: begin
          s_d.lock = s_q.lock;                    // identification word: nothing to store
        end
      endcase
    end

    // the error flag is sticky; a receiver reset write clears it,
    // but a new error in the same cycle must not be lost
    // error event wins over a clear in the same cycle
    if (link_stat_in.rx_error) begin
      s_d.rx_err = 1'b1;
    end
  end

  // every field returns to its power-up value; the answer
  // registers reset low so no stray ack follows reset
  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q.lock     <= 1'b0;
      s_q.hdr      <= 1'b0;
      s_q.node_num <= 16'h0000;
      s_q.clk_mhz  <= CLK_MHZ_RESET;
      s_q.rx_err   <= 1'b0;
      s_q.intra    <= GAP_RESET;
      s_q.inter    <= GAP_RESET;
      s_q.greet    <= 1'b0;
      s_q.rxrst    <= 1'b0;
      s_q.ack      <= 1'b0;
      s_q.nack     <= 1'b0;
      s_q.rdata    <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // gap fields leave raw: the link logic adds the one clock
  // that turns a programmed value into the real idle count
  // outputs straight from the state flops
  always_comb begin
    cfg_rsp_out.ack             = s_q.ack;
    cfg_rsp_out.nack            = s_q.nack;
    cfg_rsp_out.rdata           = s_q.rdata;
    link_ctl_out.greeting_issue = s_q.greet;
    link_ctl_out.rx_reset       = s_q.rxrst;
    link_ctl_out.intra_gap      = s_q.intra;
    link_ctl_out.inter_gap      = s_q.inter;
    header_size_select_out      = s_q.hdr;
    update_lock_out             = s_q.lock;
    node_number_out             = s_q.node_num;
    clock_rate_mhz_out          = s_q.clk_mhz;
  end

endmodule : usb_node_config_regs

// ### rtl/usb_node_cfg_pkg.sv
// package: offsets, field layout, reset values and carriers of the usb node config bank
package usb_node_cfg_pkg;

  // register offsets, kept as printed (config index space, not byte addresses)
  localparam logic [7:0] ADDR_IDENT      = 8'h00; // identification_word
  localparam logic [7:0] ADDR_NODE_SETUP = 8'h04; // node_setup
  localparam logic [7:0] ADDR_NODE_NUM   = 8'h05; // node_number
  localparam logic [7:0] ADDR_CLK_MHZ    = 8'h51; // clock_rate_mhz
  localparam logic [7:0] ADDR_LINK_CS    = 8'h80; // link_control_status

  // identification word field positions
  localparam int IDENT_CHIP_LSB = 24;             // chip_code_field 31:24
  localparam int IDENT_REV_LSB  = 8;              // revision 15:8
  localparam int IDENT_VER_LSB  = 0;              // version 7:0

  // node_setup fields
  localparam int SETUP_LOCK_BIT = 31;             // update lock
  localparam int SETUP_HDR_BIT  = 0;              // header_size_select

  // node_number and clock_rate_mhz widths
  localparam int NODE_NUM_W = 16;                 // node_number_field 15:0
  localparam int CLK_MHZ_W  = 7;                  // clock field 6:0

  // clock rate limits and reset value
  localparam logic [6:0] CLK_MHZ_RESET = 7'h19;   // 25 mhz
  localparam logic [6:0] CLK_MHZ_MIN   = 7'h05;   // lowest legal value
  localparam logic [6:0] CLK_MHZ_MAX   = 7'h64;   // highest legal value (100)

  // link_control_status fields
  localparam int LINK_RX_ERR_BIT  = 27;           // receive error flag
  localparam int LINK_RX_CRED_BIT = 26;           // credit granted to remote end
  localparam int LINK_TX_CRED_BIT = 25;           // credit held for transmit
  localparam int LINK_GREET_BIT   = 24;           // greeting_issue strobe
  localparam int LINK_RXRST_BIT   = 23;           // receiver reset strobe
  localparam int LINK_INTRA_LSB   = 11;           // intra-token gap 21:11
  localparam int LINK_INTER_LSB   = 0;            // inter-token gap 10:0
  localparam int GAP_W            = 11;           // gap field width
  localparam logic [10:0] GAP_RESET = 11'h001;    // both gap fields reset to 1

  // config access request from the tile side
  typedef struct packed {
    logic        valid;                           // one-cycle request strobe
    logic        write;                           // 1 write, 0 read
    logic [7:0]  addr;                            // register offset
    logic [31:0] wdata;                           // write data
  } cfg_req_t;

  // config access answer
  typedef struct packed {
    logic        ack;                             // request accepted
    logic        nack;                            // request refused
    logic [31:0] rdata;                           // read data, zero on writes
  } cfg_rsp_t;

  // link status arriving from the link logic
  typedef struct packed {
    logic rx_error;                               // overflow or bad token pulse
    logic rx_credit;                              // credit granted level
    logic tx_credit;                              // credit held level
  } link_stat_t;

  // link control leaving for the link logic
  typedef struct packed {
    logic             greeting_issue;             // drop credit, send greeting_token
    logic             rx_reset;                   // restart token framing
    logic [GAP_W-1:0] intra_gap;                  // idle clocks between symbols, minus one
    logic [GAP_W-1:0] inter_gap;                  // idle clocks between tokens, minus one
  } link_ctl_t;

endpackage : usb_node_cfg_pkg

// ### test/link_far_end.sv
// far-end link logic model feeding status to the bank
`timescale 1ns/100ps
module link_far_end
  import usb_node_cfg_pkg::*;
(
  input  wire logic      clk_in,       // clock
  input  wire logic      rst_in,       // reset
  input  wire logic      grant_in,     // remote grants credit
  input  wire logic      bad_tok_in,   // illegal token seen
  input  wire link_ctl_t link_ctl_in,  // control from bank
  output link_stat_t     link_stat_out // status to bank
);
  // credit levels follow greetings and grants, error is a pulse
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_stat_out <= '0;
    end else begin
      link_stat_out.rx_error <= bad_tok_in;
      link_stat_out.rx_credit <= link_stat_out.rx_credit | link_ctl_in.greeting_issue;
      link_stat_out.tx_credit <= (link_stat_out.tx_credit | grant_in) & ~link_ctl_in.greeting_issue;
    end
  end
endmodule : link_far_end

// ### test/usb_node_config_regs_checker.sv
// port assertions for the usb node config bank
`timescale 1ns/100ps
module usb_node_config_regs_checker
  import usb_node_cfg_pkg::*;
(
  input wire logic       clk_in,                 // clock
  input wire logic       rst_in,                 // reset
  input wire cfg_req_t   cfg_req_in,             // request
  input wire cfg_rsp_t   cfg_rsp_out,            // answer
  input wire link_stat_t link_stat_in,           // link status
  input wire link_ctl_t  link_ctl_out,           // link control
  input wire logic       header_size_select_out, // header mode
  input wire logic       update_lock_out,        // lock
  input wire logic [15:0] node_number_out,       // node number
  input wire logic [6:0] clock_rate_mhz_out      // clock mhz
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // accepted write and plain read qualifiers
  wire wr = cfg_req_in.valid & cfg_req_in.write & ~update_lock_out;
  wire rd = cfg_req_in.valid & ~cfg_req_in.write;
  wire [7:0] a = cfg_req_in.addr;
  sequence s_one(logic sig);
    sig ##1 !sig;
  endsequence
  property p_hdr;
    wr && a == ADDR_NODE_SETUP |=> header_size_select_out == $past(cfg_req_in.wdata[0]);
  endproperty
  property p_lock;
    update_lock_out && cfg_req_in.valid && cfg_req_in.write && a != ADDR_IDENT |=> cfg_rsp_out.nack
      && update_lock_out && $stable(node_number_out) && $stable(clock_rate_mhz_out) && $stable(link_ctl_out.inter_gap);
  endproperty
  property p_node;
    wr && a == ADDR_NODE_NUM |=> node_number_out == $past(cfg_req_in.wdata[15:0]);
  endproperty
  property p_clk_rng;
    clock_rate_mhz_out inside {[CLK_MHZ_MIN:CLK_MHZ_MAX]};
  endproperty
  property p_clk_bad;
    cfg_req_in.valid && cfg_req_in.write && a == ADDR_CLK_MHZ && (cfg_req_in.wdata[6:0] < CLK_MHZ_MIN
      || cfg_req_in.wdata[6:0] > CLK_MHZ_MAX) |=> cfg_rsp_out.nack && $stable(clock_rate_mhz_out);
  endproperty
  property p_greet;
    wr && a == ADDR_LINK_CS && cfg_req_in.wdata[24] |=> s_one(link_ctl_out.greeting_issue);
  endproperty
  property p_rxrst;
    wr && a == ADDR_LINK_CS && cfg_req_in.wdata[23] |=> s_one(link_ctl_out.rx_reset);
  endproperty
  property p_gaps;
    wr && a == ADDR_LINK_CS |=> link_ctl_out.intra_gap == $past(cfg_req_in.wdata[21:11])
      && link_ctl_out.inter_gap == $past(cfg_req_in.wdata[10:0]);
  endproperty
  property p_ident;
    rd && a == ADDR_IDENT |=> cfg_rsp_out.ack && cfg_rsp_out.rdata[23:16] == 8'h00;
  endproperty
  property p_credit;
    rd && a == ADDR_LINK_CS |=> cfg_rsp_out.rdata[31:28] == 4'h0 && cfg_rsp_out.rdata[26:22] ==
      {$past(link_stat_in.rx_credit), $past(link_stat_in.tx_credit), 3'h0};
  endproperty
  a_hdr: assert property (p_hdr) else $error("header mode not taken");
  a_lock: assert property (p_lock) else $error("locked write changed state");
  a_node: assert property (p_node) else $error("node number not taken");
  a_clk_rng: assert property (p_clk_rng) else $error("clock field out of range");
  a_clk_bad: assert property (p_clk_bad) else $error("bad clock write accepted");
  a_greet: assert property (p_greet) else $error("greeting pulse wrong");
  a_rxrst: assert property (p_rxrst) else $error("receiver reset pulse wrong");
  a_gaps: assert property (p_gaps) else $error("gap fields not taken");
  a_ident: assert property (p_ident) else $error("ident read wrong");
  a_credit: assert property (p_credit) else $error("credit bits wrong");
endmodule : usb_node_config_regs_checker
bind usb_node_config_regs usb_node_config_regs_checker i_chk (.clk_in(clk_in), .rst_in(rst_in),
  .cfg_req_in(cfg_req_in), .cfg_rsp_out(cfg_rsp_out), .link_stat_in(link_stat_in), .link_ctl_out(link_ctl_out),
  .header_size_select_out(header_size_select_out), .update_lock_out(update_lock_out),
  .node_number_out(node_number_out), .clock_rate_mhz_out(clock_rate_mhz_out));

// ### test/usb_node_config_regs_test.sv
// self-checking bench of the usb node config bank
`timescale 1ns/100ps
module usb_node_config_regs_test;
  import usb_node_cfg_pkg::*;
  logic clk_in, rst_in, grant, bad_tok, hdr, lock;
  logic [15:0] node;
  logic [6:0]  mhz;
  cfg_req_t    req;
  cfg_rsp_t    rsp;
  link_stat_t  stat;
  link_ctl_t   ctl, ctl_s;
  int          n_fail, compares, cyc;
  usb_node_config_regs #(.CHIP_CODE(8'h5a), .REVISION(8'h21), .VERSION(8'h07)) i_dut (.clk_in(clk_in),
    .rst_in(rst_in), .cfg_req_in(req), .cfg_rsp_out(rsp), .link_stat_in(stat), .link_ctl_out(ctl),
    .header_size_select_out(hdr), .update_lock_out(lock), .node_number_out(node), .clock_rate_mhz_out(mhz));
  link_far_end i_far (.clk_in(clk_in), .rst_in(rst_in), .grant_in(grant), .bad_tok_in(bad_tok),
    .link_ctl_in(ctl), .link_stat_out(stat));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one request, answer judged in the cycle it stands
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic nk,
                     input logic [31:0] rd);
    @(posedge clk_in);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk_in);
    req.valid <= 1'b0;
    #1;
    ctl_s = ctl;
    chk("ack_nack", {30'h0, rsp.ack, rsp.nack}, {30'h0, ~nk, nk});
    chk("rdata", rsp.rdata, rd);
  endtask : acc
  task automatic t_reset();
    acc(1'b0, ADDR_IDENT, 32'h0, 1'b0, 32'h5a00_2107);
    acc(1'b1, ADDR_IDENT, 32'hffff_ffff, 1'b0, 32'h0);
    acc(1'b0, ADDR_IDENT, 32'h0, 1'b0, 32'h5a00_2107);
    acc(1'b0, ADDR_NODE_SETUP, 32'h0, 1'b0, 32'h0);
    acc(1'b0, ADDR_NODE_NUM, 32'h0, 1'b0, 32'h0);
    acc(1'b0, ADDR_CLK_MHZ, 32'h0, 1'b0, 32'h19);
    acc(1'b0, ADDR_LINK_CS, 32'h0, 1'b0, 32'h0000_0801);
    chk("gap_reset", {10'h0, ctl_s.intra_gap, ctl_s.inter_gap}, {10'h0, GAP_RESET, GAP_RESET});
    acc(1'b0, 8'h10, 32'h0, 1'b1, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_cfg();
    logic [6:0] v[4] = '{7'h04, 7'h05, 7'h64, 7'h65};
    logic [6:0] e = 7'h19;
    logic nk;
    acc(1'b1, ADDR_NODE_SETUP, 32'h7fff_ffff, 1'b0, 32'h0);
    acc(1'b0, ADDR_NODE_SETUP, 32'h0, 1'b0, 32'h1);
    chk("hdr", {31'h0, hdr}, 32'h1);
    acc(1'b1, ADDR_NODE_NUM, 32'hffff_a5c3, 1'b0, 32'h0);
    acc(1'b0, ADDR_NODE_NUM, 32'h0, 1'b0, 32'h0000_a5c3);
    chk("node", {16'h0, node}, 32'h0000_a5c3);
    foreach (v[i]) begin
      nk = (v[i] < CLK_MHZ_MIN) || (v[i] > CLK_MHZ_MAX);
      if (!nk) e = v[i];
      acc(1'b1, ADDR_CLK_MHZ, {25'h1ff_ffff, v[i]}, nk, 32'h0);
      acc(1'b0, ADDR_CLK_MHZ, 32'h0, 1'b0, {25'h0, e});
    end
    acc(1'b1, ADDR_CLK_MHZ, 32'h14, 1'b0, 32'h0);
    chk("mhz", {25'h0, mhz}, 32'h14);
    $display("test config done");
  endtask : t_cfg
  task automatic t_link();
    acc(1'b1, ADDR_LINK_CS, 32'hffff_ffff, 1'b0, 32'h0);
    chk("strobes", {30'h0, ctl_s.greeting_issue, ctl_s.rx_reset}, 32'h3);
    acc(1'b0, ADDR_LINK_CS, 32'h0, 1'b0, 32'h043f_ffff);
    @(posedge clk_in);
    grant <= 1'b1;
    bad_tok <= 1'b1;
    @(posedge clk_in);
    grant <= 1'b0;
    bad_tok <= 1'b0;
    acc(1'b0, ADDR_LINK_CS, 32'h0, 1'b0, 32'h0e3f_ffff);
    acc(1'b1, ADDR_LINK_CS, 32'h0100_1802, 1'b0, 32'h0);
    chk("greet_only", {30'h0, ctl_s.greeting_issue, ctl_s.rx_reset}, 32'h2);
    chk("gaps", {10'h0, ctl_s.intra_gap, ctl_s.inter_gap}, {10'h0, 11'h003, 11'h002});
    acc(1'b0, ADDR_LINK_CS, 32'h0, 1'b0, 32'h0c00_1802);
    acc(1'b1, ADDR_LINK_CS, 32'h0080_0000, 1'b0, 32'h0);
    acc(1'b0, ADDR_LINK_CS, 32'h0, 1'b0, 32'h0400_0000);
    $display("test link done");
  endtask : t_link
  task automatic t_lock();
    acc(1'b1, ADDR_NODE_SETUP, 32'h8000_0000, 1'b0, 32'h0);
    chk("lock", {31'h0, lock}, 32'h1);
    acc(1'b1, ADDR_NODE_SETUP, 32'h1, 1'b1, 32'h0);
    acc(1'b1, ADDR_NODE_NUM, 32'h0, 1'b1, 32'h0);
    acc(1'b1, ADDR_CLK_MHZ, 32'h32, 1'b1, 32'h0);
    acc(1'b1, ADDR_LINK_CS, 32'h0100_07ff, 1'b1, 32'h0);
    chk("greet", {31'h0, ctl_s.greeting_issue}, 32'h0);
    acc(1'b0, ADDR_NODE_SETUP, 32'h0, 1'b0, 32'h8000_0000);
    acc(1'b0, ADDR_NODE_NUM, 32'h0, 1'b0, 32'h0000_a5c3);
    acc(1'b0, ADDR_CLK_MHZ, 32'h0, 1'b0, 32'h14);
    $display("test lock done");
  endtask : t_lock
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    n_fail = 0;
    compares = 0;
    cyc = 0;
    rst_in = 1'b1;
    req = '0;
    grant = 1'b0;
    bad_tok = 1'b0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_cfg();
    t_link();
    t_lock();
    stop_test();
  end
endmodule : usb_node_config_regs_test
